// >>> design/hbdp_port.sv
// Host bus port: direct I/O slave and DMA master with extended address latch
`timescale 1ns/1ns
module hbdp_port
  import hbdp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        intf_select,
  input  wire logic        chip_select_n,
  input  wire logic        reg_select_msb,
  input  wire logic        reg_select_mid,
  input  wire logic        reg_select_lsb,
  input  wire logic        upper_data_strobe_n_in,
  output logic             upper_data_strobe_n_out,
  output logic             upper_data_strobe_n_oe_n,
  input  wire logic        lower_data_strobe_n_in,
  output logic             lower_data_strobe_n_out,
  output logic             lower_data_strobe_n_oe_n,
  input  wire logic        transfer_ack_n_in,
  output logic             transfer_ack_n_out,
  output logic             transfer_ack_n_oe_n,
  input  wire logic        bus_error_n,
  input  wire logic        halt_retry_n,
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic             ad_oe_n,
  output logic             parity_high_lane,
  output logic             parity_low_lane,
  output logic             ext_addr_latch_en,
  input  wire logic        dma_start,
  input  wire logic [31:0] dma_addr,
  input  wire logic [15:0] dma_len,
  input  wire logic        dma_write,
  input  wire logic [15:0] dma_wdata,
  output logic      [15:0] dma_rdata,
  output logic             dma_rdata_valid,
  output logic             dma_busy,
  output logic             dma_error,
  output logic      [3:0]  bus_error_retry_count,
  output logic      [2:0]  dio_select,
  output logic             dio_strobe,
  output logic             dio_write,
  output logic      [15:0] dio_wdata,
  input  wire logic [15:0] dio_rdata
);

  // ==========================================================================
  // Input synchronizers
  logic [1:0] ack_sync_reg, berr_sync_reg, halt_sync_reg, uds_sync_reg, lds_sync_reg, cs_sync_reg;
  logic [2:0] sel_meta_reg, sel_sync_reg;
  always_ff @(posedge sys_clk) begin
    ack_sync_reg  <= {ack_sync_reg[0], transfer_ack_n_in};
    berr_sync_reg <= {berr_sync_reg[0], bus_error_n};
    halt_sync_reg <= {halt_sync_reg[0], halt_retry_n};
    uds_sync_reg  <= {uds_sync_reg[0], upper_data_strobe_n_in};
    lds_sync_reg  <= {lds_sync_reg[0], lower_data_strobe_n_in};
    cs_sync_reg   <= {cs_sync_reg[0], chip_select_n};
    sel_meta_reg  <= {reg_select_msb, reg_select_mid, reg_select_lsb};
    sel_sync_reg  <= sel_meta_reg;
  end

  wire ack_seen   = ~ack_sync_reg[1];
  wire berr_seen  = ~berr_sync_reg[1];
  wire halt_seen  = ~halt_sync_reg[1];
  wire any_strobe = ~uds_sync_reg[1] | ~lds_sync_reg[1];
  // strobe protocol only in this mode
  wire mode_ok    = ~intf_select;

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction

  // ==========================================================================
  // Direct I/O slave
  logic       dio_active_reg, dio_strobe_reg, ack_drive_reg;
  logic [2:0] dio_select_reg;
  logic [15:0] dio_rd_reg;
  wire dio_hit = mode_ok & ~cs_sync_reg[1] & any_strobe;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dio_active_reg <= 1'b0;
      dio_strobe_reg <= 1'b0;
      ack_drive_reg  <= 1'b0;
      dio_select_reg <= 3'h0;
      dio_rd_reg     <= 16'h0000;
    end else begin
      dio_strobe_reg <= dio_hit & ~dio_active_reg;
      dio_active_reg <= dio_hit;
      // acknowledge answers only a selected access
      ack_drive_reg  <= dio_hit & dio_active_reg;
      // msb is extended select, lsb is select-one
      if (dio_hit & ~dio_active_reg) begin
        dio_select_reg <= sel_sync_reg;
      end
      dio_rd_reg     <= dio_rdata;
    end
  end

  // ==========================================================================
  // DMA master
  hbdp_state_t state_reg, state_next;
  logic [31:0] addr_reg;
  logic [15:0] left_reg, rdata_reg;
  logic [7:0]  wait_reg;
  logic [3:0]  retry_reg;
  logic        error_reg, rvalid_reg, write_reg;
  logic [15:0] wdata_reg;
  wire  [16:0] low_inc   = {1'b0, addr_reg[15:0]} + 17'h00002;
  wire         carry_out = low_inc[16];
  wire         last_word = (left_reg == 16'h0001);
  wire         timeout   = (wait_reg == HBDP_ACK_TIMEOUT);
  // bus error ends the cycle; with halt it reruns
  wire         abort     = berr_seen & ~halt_seen;
  wire         rerun     = berr_seen & halt_seen;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HBDP_IDLE: if (dma_start & mode_ok & ~dio_hit & dma_len != 16'h0000) state_next = HBDP_XAL;
      // latch pulse before block's first cycle
      HBDP_XAL:  state_next = HBDP_T1;
      // hold off until the previous acknowledge is released, so a stale low is not taken as a new answer
      HBDP_T1:   if (~ack_seen) state_next = HBDP_T2;
      // no acknowledge by T2 inserts wait states
      HBDP_T2, HBDP_WAIT: begin
        if (rerun) state_next = HBDP_HALT;
        else if (abort | timeout) state_next = HBDP_IDLE;
        else if (ack_seen) state_next = HBDP_T3;
        else state_next = HBDP_WAIT;
      end
      HBDP_T3: begin
        if (last_word) state_next = HBDP_IDLE;
        else if (carry_out) state_next = HBDP_XAL;
        else state_next = HBDP_T1;
      end
      // Rerun after the host drops error and halt
      HBDP_HALT: if (~berr_seen & ~halt_seen) state_next = HBDP_T1;
      default:   state_next = HBDP_IDLE;
    endcase
  end

  wire in_xfer = (state_reg == HBDP_T2) | (state_reg == HBDP_WAIT);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg  <= HBDP_IDLE;
      addr_reg   <= 32'h0000_0000;
      left_reg   <= 16'h0000;
      wait_reg   <= 8'h00;
      retry_reg  <= HBDP_RETRY_RESET;
      error_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 16'h0000;
      write_reg  <= 1'b0;
      wdata_reg  <= 16'h0000;
    end else begin
      state_reg  <= state_next;
      rvalid_reg <= 1'b0;
      wait_reg   <= in_xfer ? wait_reg + 8'h01 : 8'h00;
      if (state_reg == HBDP_IDLE && state_next == HBDP_XAL) begin
        addr_reg  <= dma_addr;
        left_reg  <= dma_len;
        write_reg <= dma_write;
        wdata_reg <= dma_wdata;
        error_reg <= 1'b0;
      end
      if (in_xfer & abort & retry_reg != 4'h0) begin
        retry_reg <= retry_reg - 4'h1;
      end
      if (in_xfer & (abort | (timeout & ~rerun))) begin
        error_reg <= 1'b1;
      end
      if (state_reg == HBDP_T3) begin
        // carry out of low half forces a new latch pulse unless this was the last word
        addr_reg   <= {addr_reg[31:16] + {15'h0000, carry_out}, low_inc[15:0]};
        left_reg   <= left_reg - 16'h0001;
        wdata_reg  <= dma_wdata;
        rvalid_reg <= ~write_reg;
        rdata_reg  <= ad_in;
      end
    end
  end

  // ==========================================================================
  // Pin drivers, registered
  wire drive_bus = (state_reg != HBDP_IDLE) & (state_reg != HBDP_HALT);
  wire strobe_on = (state_next == HBDP_T2) | (state_next == HBDP_WAIT) | (state_next == HBDP_T3);
  logic [15:0] ad_next;
  always_comb begin
    // a carry-out latch shows the incremented upper half, not the stale request address
    if (state_next == HBDP_XAL) ad_next = (state_reg == HBDP_T3) ? addr_reg[31:16] + 16'h0001 : dma_addr[31:16];
    else if (state_reg == HBDP_XAL | state_next == HBDP_XAL) ad_next = addr_reg[31:16];
    else if (write_reg) ad_next = wdata_reg;
    else ad_next = dio_rd_reg;
  end
  // Parity follows the very value placed on the lanes, DIRECT_IO_ACCESS data included
  wire [15:0] ad_pin = dio_hit ? dio_rd_reg : ad_next;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      upper_data_strobe_n_out  <= 1'b1;
      upper_data_strobe_n_oe_n <= 1'b1;
      lower_data_strobe_n_out  <= 1'b1;
      lower_data_strobe_n_oe_n <= 1'b1;
      transfer_ack_n_out       <= 1'b1;
      transfer_ack_n_oe_n      <= 1'b1;
      ad_out                   <= 16'h0000;
      ad_oe_n                  <= 1'b1;
      parity_high_lane         <= 1'b0;
      parity_low_lane          <= 1'b0;
      ext_addr_latch_en        <= 1'b0;
    end else begin
      upper_data_strobe_n_oe_n <= ~(drive_bus | state_next == HBDP_XAL);
      lower_data_strobe_n_oe_n <= ~(drive_bus | state_next == HBDP_XAL);
      upper_data_strobe_n_out  <= ~strobe_on;
      lower_data_strobe_n_out  <= ~strobe_on;
      // acknowledge pin driven only when selected
      transfer_ack_n_oe_n      <= ~dio_hit;
      transfer_ack_n_out       <= ~(ack_drive_reg & dio_hit);
      ad_out                   <= ad_pin;
      ad_oe_n                  <= ~((dio_hit & ~dio_write) | (state_next == HBDP_XAL) | (drive_bus & write_reg));
      // odd parity per byte lane; valid with latch pulse
      parity_high_lane         <= odd_par(ad_pin[15:8]);
      parity_low_lane          <= odd_par(ad_pin[7:0]);
      // latch pulse for upper address half
      ext_addr_latch_en        <= (state_next == HBDP_XAL);
    end
  end

  // ==========================================================================
  // User side outputs
  logic dio_write_reg;
  logic [15:0] dio_wdata_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dio_write_reg <= 1'b0;
      dio_wdata_reg <= 16'h0000;
    end else begin
      dio_write_reg <= 1'b0;
      dio_wdata_reg <= ad_in;
    end
  end
  assign dma_rdata             = rdata_reg;
  assign dma_rdata_valid       = rvalid_reg;
  assign dma_busy              = (state_reg != HBDP_IDLE);
  assign dma_error             = error_reg;
  assign bus_error_retry_count = retry_reg;
  assign dio_select            = dio_select_reg;
  assign dio_strobe            = dio_strobe_reg;
  assign dio_wdata             = dio_wdata_reg;
  assign dio_write             = dio_write_reg;
endmodule

// >>> pkg/hbdp_pkg.sv
// Package for the host bus direct I/O and DMA port: constants and state types
package hbdp_pkg;
  // ==========================================================================
  // Widths and reset values
  localparam int          HBDP_ADDR_W       = 32;
  localparam int          HBDP_DATA_W       = 16;
  localparam int          HBDP_LEN_W        = 16;
  localparam int          HBDP_RETRY_W      = 4;
  localparam logic [3:0]  HBDP_RETRY_RESET  = 4'hF;
  localparam logic [15:0] HBDP_LOW_MASK     = 16'hFFFF;
  // Wait cycles tolerated before giving up on an absent acknowledge
  localparam logic [7:0]  HBDP_ACK_TIMEOUT  = 8'hFF;

  // ==========================================================================
  // Master cycle states
  typedef enum logic [2:0] {
    HBDP_IDLE  = 3'b000,
    HBDP_XAL   = 3'b001,
    HBDP_T1    = 3'b010,
    HBDP_T2    = 3'b011,
    HBDP_WAIT  = 3'b100,
    HBDP_T3    = 3'b101,
    HBDP_HALT  = 3'b110
  } hbdp_state_t;
endpackage

// >>> verif/hbdp_bus_model.sv
// Behavioural slave on the far side of the host bus during DMA
`timescale 1ns/1ns
module hbdp_bus_model (
  input  logic        clk,
  input  logic        strobe_n,
  input  logic [3:0]  delay,
  input  logic [1:0]  mode,
  output logic        ack_n,
  output logic        berr_n,
  output logic        halt_n,
  output logic [15:0] rdata
);
  logic [3:0]  cnt;
  logic [2:0]  ecnt;
  logic        used;
  logic [15:0] served;
  initial begin
    {ack_n, berr_n, halt_n, used} = 4'hE;
    {cnt, ecnt, served, rdata} = 39'h0;
  end
  // ==========================================================================
  // Responder: one error per mode setting, held four cycles
  always @(posedge clk) begin
    #1;
    if (mode == 2'h0) used = 1'b0;
    if (ecnt != 3'h0) begin
      ecnt = ecnt - 3'h1;
      if (ecnt == 3'h0) {berr_n, halt_n} = 2'h3;
    end
    else if (strobe_n) begin
      if (!ack_n) served = served + 16'h1;
      {ack_n, cnt, rdata} = {1'b1, 4'h0, ~rdata};
    end
    else if (cnt < delay) cnt = cnt + 4'h1;
    else if (mode != 2'h0 && !used) {berr_n, halt_n, used, ecnt} = {1'b0, mode != 2'h2, 1'b1, 3'h4};
    else {ack_n, rdata} = {1'b0, 16'hC0DE + served};
  end
endmodule

// >>> verif/hbdp_port_properties.sv
// Concurrent checks on the host bus port pins and DMA status
`timescale 1ns/1ns
module hbdp_port_properties (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic        intf_select,
  input logic        chip_select_n,
  input logic        dma_start,
  input logic [15:0] dma_len,
  input logic        dma_busy,
  input logic        dma_error,
  input logic        dma_rdata_valid,
  input logic        upper_data_strobe_n_out,
  input logic        upper_data_strobe_n_oe_n,
  input logic        lower_data_strobe_n_out,
  input logic        lower_data_strobe_n_oe_n,
  input logic        transfer_ack_n_in,
  input logic        transfer_ack_n_oe_n,
  input logic        halt_retry_n,
  input logic [15:0] ad_out,
  input logic        ad_oe_n,
  input logic        parity_high_lane,
  input logic        parity_low_lane,
  input logic        ext_addr_latch_en,
  input logic [3:0]  bus_error_retry_count
);
  // ==========================================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reset_float_a: assert property (disable iff (1'b0) sys_rst |=>
    upper_data_strobe_n_oe_n && transfer_ack_n_oe_n && ad_oe_n && !ext_addr_latch_en) else $error("pin driven in reset");
  latch_once_a: assert property (ext_addr_latch_en |=> !ext_addr_latch_en) else $error("latch pulse too long");
  start_latch_a: assert property (dma_start && !dma_busy && !intf_select && chip_select_n && dma_len != 16'h0000
    |=> ext_addr_latch_en) else $error("no latch pulse after start");
  latch_drive_a: assert property (ext_addr_latch_en |-> !ad_oe_n) else $error("latch without address");
  strobe_pair_a: assert property (!upper_data_strobe_n_oe_n |-> !lower_data_strobe_n_oe_n
    && upper_data_strobe_n_out == lower_data_strobe_n_out && transfer_ack_n_oe_n) else $error("strobes split");
  ack_sync_a: assert property (dma_rdata_valid |-> !$past(transfer_ack_n_in, 2)) else $error("ack used unsynced");
  abort_idle_a: assert property ($rose(dma_error) |-> ##[0:3] !dma_busy) else $error("error cycle kept on");
  retry_step_a: assert property ($changed(bus_error_retry_count) |->
    bus_error_retry_count == $past(bus_error_retry_count) - 4'h1) else $error("retry count jump");
  halt_hold_a: assert property (!$past(halt_retry_n, 2) && !$past(halt_retry_n, 3)
    |-> $stable(bus_error_retry_count)) else $error("count moved in halt");
  parity_odd_a: assert property (!ad_oe_n && $stable(ad_out) |-> parity_high_lane == ~^ad_out[15:8]
    && parity_low_lane == ~^ad_out[7:0]) else $error("parity not odd");
endmodule

// >>> verif/hbdp_port_tb.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ns
module hbdp_port_tb;
  import hbdp_pkg::*;
  logic        sys_clk, sys_rst, intf_select, chip_select_n, reg_select_msb, reg_select_mid, reg_select_lsb;
  logic        upper_data_strobe_n_out, upper_data_strobe_n_oe_n, lower_data_strobe_n_out, lower_data_strobe_n_oe_n;
  logic        transfer_ack_n_out, transfer_ack_n_oe_n, ad_oe_n, parity_high_lane, parity_low_lane, ext_addr_latch_en;
  logic        dma_start, dma_write, dma_rdata_valid, dma_busy, dma_error, dio_strobe, dio_write;
  logic        bus_error_n, halt_retry_n, tb_strb_n, m_ack_n;
  logic [15:0] ad_in, ad_out, dma_len, dma_wdata, dma_rdata, dio_wdata, dio_rdata, xal_v;
  logic [31:0] dma_addr;
  logic [3:0]  bus_error_retry_count, dly;
  logic [2:0]  dio_select;
  logic [1:0]  mode;
  int          mismatches, num_checks, xal_n, rd_n, r0, dio_n;
  // Released strobes follow the bench's tb_strb_n level
  wire upper_data_strobe_n_in = upper_data_strobe_n_oe_n ? tb_strb_n : upper_data_strobe_n_out;
  wire lower_data_strobe_n_in = lower_data_strobe_n_oe_n ? tb_strb_n : lower_data_strobe_n_out;
  wire transfer_ack_n_in = transfer_ack_n_oe_n ? m_ack_n : transfer_ack_n_out;
  hbdp_port hbdp_port_inst (.*);
  hbdp_bus_model hbdp_bus_model_inst (.clk(sys_clk), .strobe_n(upper_data_strobe_n_in | upper_data_strobe_n_oe_n),
    .delay(dly), .mode(mode), .ack_n(m_ack_n), .berr_n(bus_error_n), .halt_n(halt_retry_n), .rdata(ad_in));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Shared tasks
  task tick; @(posedge sys_clk); #2; endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task results;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task dma(input logic [31:0] a, input logic [15:0] n);
    int i;
    {dma_addr, dma_len, dma_start, xal_n, r0} = {a, n, 1'b1, 32'h0, rd_n};
    tick;
    dma_start = 1'b0;
    tick;
    for (i = 0; i < 3000 && dma_busy !== 1'b0; i++) tick;
    if (i == 3000) begin mismatches++; results; end
    repeat (8) tick;
  endtask
  always @(posedge sys_clk) begin
    if (ext_addr_latch_en === 1'b1) {xal_n, xal_v} <= {xal_n + 1, ad_out};
    if (dio_strobe === 1'b1) dio_n <= dio_n + 1;
    if (dma_rdata_valid === 1'b1) begin
      chk(dma_rdata, 16'hC0DE + rd_n[15:0]);
      rd_n <= rd_n + 1;
    end
  end
  // ==========================================================================
  // Scenarios
  task t_read;
    dma(32'h1234_0100, 16'h3);
    chk(xal_n, 1);
    chk(xal_v, 16'h1234);
    chk(rd_n - r0, 3);
  endtask
  task t_slow; dly = 4'h6; dma(32'h00AB_0000, 16'h2); chk(rd_n - r0, 2); dly = 4'h0; endtask
  task t_carry; dma(32'h0001_FFFE, 16'h2); chk(xal_n, 2); chk(xal_v, 16'h0002); endtask
  task t_berr;
    mode = 2'h1;
    dma(32'h0000_0040, 16'h1);
    chk({dma_error, bus_error_retry_count}, 5'h1E);
    chk(rd_n - r0, 0);
    mode = 2'h0;
    tick;
  endtask
  task t_halt;
    mode = 2'h2;
    dma(32'h0000_0080, 16'h1);
    chk({dma_error, bus_error_retry_count}, 5'h0E);
    chk(rd_n - r0, 1);
    mode = 2'h0;
  endtask
  task t_mode; intf_select = 1'b1; dma(32'h0055_0000, 16'h1); chk(xal_n, 0); intf_select = 1'b0; endtask
  task t_dio;
    int i;
    {chip_select_n, reg_select_msb, reg_select_mid, reg_select_lsb, tb_strb_n} = 5'h0A;
    for (i = 0; i < 50 && transfer_ack_n_in !== 1'b0; i++) tick;
    if (i == 50) begin mismatches++; results; end
    chk(dio_n, 1);
    chk({dio_select, transfer_ack_n_oe_n}, 4'hA);
    chk(ad_out, 16'h5A3C);
    {chip_select_n, tb_strb_n} = 2'h3;
    repeat (6) tick;
    chk(transfer_ack_n_oe_n, 1);
  endtask
  initial begin
    {sys_rst, intf_select, chip_select_n, reg_select_msb, reg_select_mid, reg_select_lsb} = 6'h28;
    {dma_start, dma_write, dma_addr, dma_len, dma_wdata, tb_strb_n, dly, mode} = {66'h0, 1'b1, 6'h00};
    dio_n = 0;
    {dio_rdata, mismatches, num_checks, xal_n, rd_n} = {16'h5A3C, 128'h0};
    repeat (16) tick;
    chk({upper_data_strobe_n_oe_n, transfer_ack_n_oe_n, ad_oe_n, ext_addr_latch_en}, 4'hE);
    chk(bus_error_retry_count, 4'hF);
    sys_rst = 1'b0;
    tick;
    t_read;
    t_slow;
    t_carry;
    t_berr;
    t_halt;
    t_mode;
    t_dio;
    results;
  end
endmodule
bind hbdp_port hbdp_port_properties hbdp_port_properties_inst (.*);
